// ---- hw/aics_regs.vh ----
`ifndef AICS_REGS_VH
`define AICS_REGS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define AICS_ADDR_W          4
`define AICS_OFS_INCLK       4'h0
`define AICS_OFS_REFCTL      4'h4
`define AICS_OFS_STATUS      4'h8

// ****************************************
// Field positions and masks
// ****************************************
`define AICS_INSEL_HI        7
`define AICS_INSEL_LO        5
`define AICS_CKDIV_HI        2
`define AICS_CKDIV_LO        0
`define AICS_OPA_EN_BIT      7
`define AICS_BG_EN_BIT       6
`define AICS_REFSEL_HI       3
`define AICS_REFSEL_LO       0
`define AICS_INCLK_MASK      8'he7
`define AICS_REFCTL_MASK     8'hcf

// ****************************************
// Reset values
// ****************************************
`define AICS_INCLK_RST       8'h00
`define AICS_REFCTL_RST      8'h00

// ****************************************
// Internal input codes
// ****************************************
`define AICS_IN_AVDD         3'h1
`define AICS_IN_AVDD_2       3'h2
`define AICS_IN_AVDD_4       3'h3
`define AICS_IN_VR           3'h5
`define AICS_IN_VR_2         3'h6
`define AICS_IN_VR_4         3'h7

// ****************************************
// Input source encodings on o_input_source
// ****************************************
`define AICS_SRC_EXT         3'h0
`define AICS_SRC_AVDD        3'h1
`define AICS_SRC_AVDD_2      3'h2
`define AICS_SRC_AVDD_4      3'h3
`define AICS_SRC_VR          3'h4
`define AICS_SRC_VR_2        3'h5
`define AICS_SRC_VR_4        3'h6

// ****************************************
// Reference codes
// ****************************************
`define AICS_REF_AVDD        4'h0
`define AICS_REF_VREF        4'h1
`define AICS_REF_VREF_X2     4'h2
`define AICS_REF_VREF_X3     4'h3
`define AICS_REF_VREF_X4     4'h4

`endif

// ---- hw/aics_clk_div.v ----
`timescale 1ns/1ps
// ****************************************
// Converter clock enable divider
// ****************************************
module aics_clk_div
(
  input  wire       i_sys_clk,
  input  wire       i_arst_n,
  input  wire [2:0] i_div_sel,
  output reg        o_tick
);

  reg  [6:0] cnt_ff;
  wire [6:0] last_cnt;

  assign last_cnt = (7'h01 << i_div_sel) - 7'h01;

  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_ff <= 7'h00;
      o_tick <= 1'b0;
    end
    else
    begin
      // A shrinking ratio restarts the count rather than running past it
      if (cnt_ff >= last_cnt)
      begin
        cnt_ff <= 7'h00;
        o_tick <= 1'b1;
      end
      else
      begin
        cnt_ff <= cnt_ff + 7'h01;
        o_tick <= 1'b0;
      end
    end
  end

endmodule // aics_clk_div

// ---- hw/aics_top.v ----
// Contract
// - Internal select 000 leaves only the chosen external channel on the input
// - Codes 001, 010, 011 route supply at full, half, quarter
// - Codes 101, 110, 111 route op-amp output at full, half, quarter
// - Code 100 behaves exactly as 000
// - Clock field divides system clock by two to the field value
// - Reference register bit 6 enables the bandgap buffer
// - Reference code 0000 selects supply, 0001 the external reference pin
// - Unimplemented bits ignore writes and read zero
// - Reference codes 0010..0100 select reference pin times two, three, four
`timescale 1ns/1ps
`include "aics_regs.vh"

module aics_top
(
  input  wire                    i_sys_clk,
  input  wire                    i_arst_n,
  input  wire [`AICS_ADDR_W-1:0] i_avs_address,
  input  wire                    i_avs_read,
  input  wire                    i_avs_write,
  input  wire [31:0]             i_avs_writedata,
  input  wire [3:0]              i_avs_byteenable,
  output reg  [31:0]             o_avs_readdata,
  output reg                     o_avs_waitrequest,
  input  wire [1:0]              i_external_channel_select,
  output reg  [1:0]              o_external_channel,
  output reg                     o_external_connect,
  output reg  [2:0]              o_input_source,
  output reg                     o_converter_clock,
  output reg                     o_opamp_enable,
  output reg                     o_bandgap_buffer_enable,
  output reg  [3:0]              o_reference_select,
  output reg                     o_reference_invalid
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0]  inclk_ff;
  reg  [7:0]  refctl_ff;
  reg         ack_ff;
  reg  [1:0]  ext_sel_meta_ff;
  reg  [1:0]  ext_sel_ff;
  reg  [2:0]  nxt_src;
  reg  [31:0] nxt_rdata;
  reg         ref_bad;
  wire        div_tick;
  wire        req;
  wire        wr_inclk;
  wire        wr_refctl;

  // One wait state per access keeps read data a plain registered path
  assign req       = (i_avs_read | i_avs_write) & ~ack_ff;
  assign wr_inclk  = req & i_avs_write & i_avs_byteenable[0] &
                     (i_avs_address == `AICS_OFS_INCLK);
  assign wr_refctl = req & i_avs_write & i_avs_byteenable[0] &
                     (i_avs_address == `AICS_OFS_REFCTL);

  // ****************************************
  // Bus slave
  // ****************************************
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      inclk_ff          <= `AICS_INCLK_RST;
      refctl_ff         <= `AICS_REFCTL_RST;
      ack_ff            <= 1'b0;
      o_avs_readdata    <= 32'h00000000;
      o_avs_waitrequest <= 1'b1;
    end
    else
    begin
      ack_ff            <= req;
      o_avs_waitrequest <= ~req;
      if (wr_inclk)
        inclk_ff <= i_avs_writedata[7:0] & `AICS_INCLK_MASK;
      if (wr_refctl)
        refctl_ff <= i_avs_writedata[7:0] & `AICS_REFCTL_MASK;
      if (req & i_avs_read)
        o_avs_readdata <= nxt_rdata;
    end
  end

  // Unmapped addresses read zero and drop writes
  always @*
  begin
    case (i_avs_address)
      `AICS_OFS_INCLK:  nxt_rdata = {24'h000000, inclk_ff};
      `AICS_OFS_REFCTL: nxt_rdata = {24'h000000, refctl_ff};
      `AICS_OFS_STATUS: nxt_rdata = {25'h0, o_reference_invalid,
                                     o_external_connect, o_converter_clock,
                                     1'b0, o_input_source};
      default:          nxt_rdata = 32'h00000000;
    endcase
  end

  // ****************************************
  // Input source decode
  // ****************************************
  always @*
  begin
    case (inclk_ff[`AICS_INSEL_HI:`AICS_INSEL_LO])
      `AICS_IN_AVDD:   nxt_src = `AICS_SRC_AVDD;
      `AICS_IN_AVDD_2: nxt_src = `AICS_SRC_AVDD_2;
      `AICS_IN_AVDD_4: nxt_src = `AICS_SRC_AVDD_4;
      `AICS_IN_VR:     nxt_src = `AICS_SRC_VR;
      `AICS_IN_VR_2:   nxt_src = `AICS_SRC_VR_2;
      `AICS_IN_VR_4:   nxt_src = `AICS_SRC_VR_4;
      default:         nxt_src = `AICS_SRC_EXT;
    endcase
  end

  always @*
  begin
    case (refctl_ff[`AICS_REFSEL_HI:`AICS_REFSEL_LO])
      `AICS_REF_AVDD,
      `AICS_REF_VREF,
      `AICS_REF_VREF_X2,
      `AICS_REF_VREF_X3,
      `AICS_REF_VREF_X4: ref_bad = 1'b0;
      default:           ref_bad = 1'b1;
    endcase
  end

  // ****************************************
  // Converter clock divider
  // ****************************************
  aics_clk_div u_clk_div
  (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_div_sel (inclk_ff[`AICS_CKDIV_HI:`AICS_CKDIV_LO]),
    .o_tick    (div_tick)
  );

  // ****************************************
  // External channel synchroniser
  // ****************************************
  // External select comes from another block's pins
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ext_sel_meta_ff    <= 2'h0;
      ext_sel_ff         <= 2'h0;
      o_external_channel <= 2'h0;
    end
    else
    begin
      ext_sel_meta_ff    <= i_external_channel_select;
      ext_sel_ff         <= ext_sel_meta_ff;
      o_external_channel <= ext_sel_ff;
    end
  end

  // ****************************************
  // Input source outputs
  // ****************************************
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_external_connect <= 1'b1;
      o_input_source     <= `AICS_SRC_EXT;
    end
    else
    begin
      // Internal source overrides the pin when both are chosen
      o_external_connect <= (nxt_src == `AICS_SRC_EXT);
      o_input_source     <= nxt_src;
    end
  end

  // ****************************************
  // Converter clock output
  // ****************************************
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_converter_clock <= 1'b0;
    end
    else
    begin
      o_converter_clock <= div_tick;
    end
  end

  // ****************************************
  // Reference and op-amp outputs
  // ****************************************
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_opamp_enable          <= 1'b0;
      o_bandgap_buffer_enable <= 1'b0;
      o_reference_select      <= `AICS_REF_AVDD;
      o_reference_invalid     <= 1'b0;
    end
    else
    begin
      o_opamp_enable          <= refctl_ff[`AICS_OPA_EN_BIT];
      o_bandgap_buffer_enable <= refctl_ff[`AICS_BG_EN_BIT];
      // Reserved codes pass through; the flag lets the converter refuse them
      o_reference_select      <= refctl_ff[`AICS_REFSEL_HI:`AICS_REFSEL_LO];
      o_reference_invalid     <= ref_bad;
    end
  end

endmodule // aics_top

// ---- test/aics_top_sva.sv ----
`timescale 1ns/1ps
`include "aics_regs.vh"
// ****************************************
// Port level checks
// ****************************************
module aics_top_sva
(
  input wire                    i_sys_clk,
  input wire                    i_arst_n,
  input wire [`AICS_ADDR_W-1:0] i_avs_address,
  input wire                    i_avs_read,
  input wire                    i_avs_write,
  input wire [31:0]             o_avs_readdata,
  input wire                    o_avs_waitrequest,
  input wire [1:0]              i_external_channel_select,
  input wire [1:0]              o_external_channel,
  input wire                    o_external_connect,
  input wire [2:0]              o_input_source,
  input wire                    o_opamp_enable,
  input wire                    o_bandgap_buffer_enable,
  input wire [3:0]              o_reference_select,
  input wire                    o_reference_invalid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // Outputs of the reference register may only move after an accepted write there
  wire wr_ref = i_avs_write && !o_avs_waitrequest && (i_avs_address == `AICS_OFS_REFCTL);
  property p_conn; o_external_connect == (o_input_source == 3'h0); endproperty
  a_conn: assert property (p_conn) else $error("connect flag and source disagree");
  property p_src; o_input_source != 3'h7; endproperty
  a_src: assert property (p_src) else $error("source code out of range");
  property p_ack; $rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("access not answered after one wait");
  property p_ack1; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_ack1: assert property (p_ack1) else $error("answer held too long");
  property p_inv; o_reference_invalid == (o_reference_select > 4'h4); endproperty
  a_inv: assert property (p_inv) else $error("invalid flag wrong");
  property p_ref; $changed(o_reference_select) |-> $past(wr_ref); endproperty
  a_ref: assert property (p_ref) else $error("reference moved without write");
  property p_bg; $changed(o_bandgap_buffer_enable) |-> $past(wr_ref); endproperty
  a_bg: assert property (p_bg) else $error("bandgap moved without write");
  property p_opa; $changed(o_opamp_enable) |-> $past(wr_ref); endproperty
  a_opa: assert property (p_opa) else $error("op-amp moved without write");
  property p_pad;
    i_avs_read && !o_avs_waitrequest && (i_avs_address == `AICS_OFS_INCLK)
      |-> (o_avs_readdata[31:8] == 24'h0) && (o_avs_readdata[4:3] == 2'h0);
  endproperty
  a_pad: assert property (p_pad) else $error("unused bits read nonzero");
  property p_ch; $changed(o_external_channel) |-> o_external_channel == $past(i_external_channel_select, 3); endproperty
  a_ch: assert property (p_ch) else $error("channel latency wrong");
endmodule // aics_top_sva

bind aics_top aics_top_sva u_sva (.i_sys_clk, .i_arst_n, .i_avs_address, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_external_channel_select,
  .o_external_channel, .o_external_connect, .o_input_source, .o_opamp_enable,
  .o_bandgap_buffer_enable, .o_reference_select, .o_reference_invalid);

// ---- test/aics_top_tb.sv ----
`timescale 1ns/1ps
`include "aics_regs.vh"
`define CHK(g, e) begin checks_done = checks_done + 1; if ((g) !== (e)) begin fail_count = fail_count + 1; $display("[FAIL] %0t %h %h", $time, g, e); end end
// ****************************************
// Register access bench
// ****************************************
module aics_top_tb;
  reg         c = 1'b0, rn = 1'b0, rd = 1'b0, we = 1'b0;
  reg  [3:0]  adr = 4'h0, be = 4'hf, rsel;
  reg  [31:0] wd = 32'h0, rdv;
  reg  [1:0]  ch = 2'h2;
  wire [31:0] q;
  wire [1:0]  xch;
  wire [2:0]  src;
  wire        wq, xc, ck, opa, bg, inv;
  wire [3:0]  rs;
  integer     fail_count = 0, checks_done = 0, i, k;
  always #2 c = ~c;
  aics_top uut (.i_sys_clk(c), .i_arst_n(rn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(we), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(q),
    .o_avs_waitrequest(wq), .i_external_channel_select(ch), .o_external_channel(xch),
    .o_external_connect(xc), .o_input_source(src), .o_converter_clock(ck),
    .o_opamp_enable(opa), .o_bandgap_buffer_enable(bg), .o_reference_select(rs),
    .o_reference_invalid(inv));
  task print_verdict;
    begin
      if (fail_count == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task acc(input w, input [3:0] a, input [7:0] d);
    integer n;
    begin
      @(posedge c);
      rd <= !w;
      we <= w;
      adr <= a;
      wd <= {24'h0, d};
      n = 0;
      @(posedge c);
      while (wq !== 1'b0 && n < 100)
      begin
        n = n + 1;
        @(posedge c);
      end
      if (n == 100)
        fail_count = fail_count + 1;
      rdv = q;
      rd <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task rdc(input [3:0] a, input [31:0] e);
    begin
      acc(1'b0, a, 8'h00);
      `CHK(rdv, e)
    end
  endtask
  initial
  begin
    repeat (16) @(posedge c);
    rn <= 1'b1;
    rdc(`AICS_OFS_INCLK, 32'h0);
    rdc(`AICS_OFS_REFCTL, 32'h0);
    acc(1'b1, `AICS_OFS_INCLK, 8'hff);
    rdc(`AICS_OFS_INCLK, 32'he7);
    acc(1'b1, `AICS_OFS_REFCTL, 8'hff);
    rdc(`AICS_OFS_REFCTL, 32'hcf);
    @(negedge c);
    `CHK({opa, bg, rs, inv}, 7'h7f)
    @(posedge c);
    be <= 4'h0;
    acc(1'b1, `AICS_OFS_REFCTL, 8'h00);
    be <= 4'hf;
    rdc(`AICS_OFS_REFCTL, 32'hcf);
    acc(1'b1, 4'hc, 8'h55);
    rdc(4'hc, 32'h0);
    for (i = 0; i < 5; i = i + 1)
    begin
      rsel = i;
      acc(1'b1, `AICS_OFS_REFCTL, {rsel != 4'h0, rsel[1], 2'h3, rsel});
      repeat (2) @(negedge c);
      `CHK({opa, bg, rs, inv}, {rsel != 4'h0, rsel[1], rsel, 1'b0})
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      rsel = i;
      acc(1'b1, `AICS_OFS_INCLK, {rsel[2:0], 5'h00});
      repeat (2) @(negedge c);
      `CHK({xc, src}, {i == 0 || i == 4, (i == 4) ? 3'h0 : rsel[2:0] - (i > 4)})
    end
    `CHK(xch, 2'h2)
    @(posedge c);
    ch <= 2'h1;
    repeat (3) @(negedge c);
    `CHK(xch, 2'h2)
    @(negedge c);
    `CHK(xch, 2'h1)
    rdc(`AICS_OFS_STATUS, 32'h16);
    for (i = 0; i < 8; i = i + 1)
    begin
      rsel = i;
      acc(1'b1, `AICS_OFS_INCLK, {5'h00, rsel[2:0]});
      repeat (140) @(negedge c);
      k = 0;
      repeat (256)
      begin
        @(negedge c);
        k = k + ck;
      end
      `CHK(k, 256 >> i)
    end
    print_verdict;
  end
  initial
  begin
    #100000;
    fail_count = fail_count + 1;
    print_verdict;
  end
endmodule // aics_top_tb
